// File: hdl/cfp_regs.vh
// Constants for the flag register and working register pointers.
// Assumes inclusion by the design files of this block only.
`ifndef CFP_REGS_VH
`define CFP_REGS_VH
`define CFP_OFF_FLAGS 12'h0e7
`define CFP_OFF_PTR0 12'h0e8
`define CFP_OFF_PTR1 12'h0e9
`define CFP_BYTE_ADDR(idx) ((idx) << 2)
`define CFP_FLAG_CARRY 7
`define CFP_FLAG_ZERO 6
`define CFP_FLAG_SIGN 5
`define CFP_FLAG_OVF 4
`define CFP_FLAG_BCDKIND 3
`define CFP_FLAG_HALF 2
`define CFP_FLAG_USER 1
`define CFP_FLAG_MEMSEL 0
`define CFP_PTR_SPLIT 2
`define CFP_PTR_MASK 8'hfc
`define CFP_GROUP_D 4'hd
`define CFP_FLAGS_RST 8'h00
`define CFP_PTR_RST 8'h00
`endif

// File: hdl/cfp_flag_eval.v
// Pure combinational flag evaluation for one ALU result.
// Assumes the ALU supplies result, operands, subtract select and word select for the operation.
`timescale 1ns/1ns
`default_nettype none
module cfp_flag_eval (
  // Operation result and operands.
  input wire [15:0] aluResult,
  input wire [15:0] aluOpA,
  input wire [15:0] aluOpB,
  input wire aluIsSub,
  input wire aluIsWord,
  // Derived flags.
  output wire zeroOut,
  output wire signOut,
  output wire ovfOut,
  output wire halfOut
);
  wire [15:0] effB;
  wire topA;
  wire topB;
  // Zero and sign follow the accumulator width.
  assign zeroOut = aluIsWord ? (aluResult == 16'h0000) : (aluResult[7:0] == 8'h00);
  assign signOut = aluIsWord ? aluResult[15] : aluResult[7];
  // Overflow: operands of equal sign give a result of the other sign.
  assign effB = aluIsSub ? ~aluOpB : aluOpB;
  assign topA = aluIsWord ? aluOpA[15] : aluOpA[7];
  assign topB = aluIsWord ? effB[15] : effB[7];
  assign ovfOut = (topA == topB) && (signOut != topA);
  // Half carry out of, or borrow into, bit 3 of a byte.
  assign halfOut = aluOpA[4] ^ aluOpB[4] ^ aluResult[4];
endmodule // cfp_flag_eval
`default_nettype wire

// File: hdl/cfp_addr_map.v
// Working register number to absolute register file address.
// Assumes pointer values already hold zero in their two low bits.
`timescale 1ns/1ns
`default_nettype none
`include "cfp_regs.vh"
module cfp_addr_map (
  // Pointer state.
  input wire [7:0] ptrZero,
  input wire [7:0] ptrOne,
  input wire splitMode,
  // Working register number.
  input wire [3:0] workNum,
  // Absolute address out.
  output wire [7:0] absAddr
);
  wire [7:0] singleBase;
  // Single mode aligns to an even 8-group, i.e. a 16-register boundary.
  assign singleBase = {ptrZero[7:4], 4'h0}; // [RULE17]
  // Twin mode picks a pointer by the number's top bit, offsets 0 to 7.
  assign absAddr = splitMode ?
    (workNum[3] ? ({ptrOne[7:3], 3'b000} + {5'b00000, workNum[2:0]}) // [RULE18]
                : ({ptrZero[7:3], 3'b000} + {5'b00000, workNum[2:0]})) :
    (singleBase + {4'h0, workNum}); // [RULE16]
endmodule // cfp_addr_map
`default_nettype wire

// File: hdl/cfp_core_regs.v
// Condition flags and working register pointers of the core, with APB access.
// Assumes the decoder gives one-cycle command pulses and ALU results synchronously.
`timescale 1ns/1ns
`default_nettype none
`include "cfp_regs.vh"
// Operation
// RULE1: Carry set on carry out of top bit.
// RULE2: Carry forced set, cleared or inverted by commands.
// RULE3: Zero flag set when affected result is zero.
// RULE4: Sign copies result bit 7 or 15.
// RULE5: Sign and overflow update with zero flag.
// RULE6: Overflow set on signed range error.
// RULE7: Remember last arithmetic was add or subtract.
// RULE8: Half carry from bit 3 on byte ops.
// RULE9: User bit changes only by explicit instruction.
// RULE10: Memory select set for data, cleared for code.
// RULE11: Pointer set commands choose twin or single mode.
// RULE12: Split bit in both pointers marks twin mode.
// RULE13: Pointer bits one and zero stay zero.
// RULE14: Pointer bits 7 to 3 hold group index.
// RULE15: Address high nibble group, low nibble register.
// RULE16: Single mode adds register number to pointer zero.
// RULE17: Single mode window aligned to even group.
// RULE18: Twin mode uses pointer one for r8-r15.
// RULE19: Group D reachable only through pointers.
// RULE20: Software treats unused pointer one as reserved.
module cfp_core_regs (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_b,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // ALU result for flag updates.
  input wire aluUpdate,
  input wire aluCarryUpdate,
  input wire aluArith,
  input wire aluIsSub,
  input wire aluIsWord,
  input wire aluCarryOut,
  input wire [15:0] aluResult,
  input wire [15:0] aluOpA,
  input wire [15:0] aluOpB,
  // Flag commands from the decoder.
  input wire set_msb_out,
  input wire clear_msb_out,
  input wire invert_msb_out,
  input wire userSet,
  input wire userClear,
  input wire select_data_space,
  input wire select_code_space,
  // Pointer commands from the decoder.
  input wire set_pointer_zero,
  input wire set_pointer_one,
  input wire set_single_pointer,
  input wire [4:0] cmdGroupIndex,
  // Register address translation.
  input wire [7:0] regAddr,
  output wire [7:0] absRegAddr,
  output wire regAddrValid,
  // State outputs.
  output wire [7:0] condition_flags,
  output wire memory_space_sel,
  output wire pointer_split_mode
);
  reg [7:0] flagsReg;
  reg [7:0] flagsNext;
  reg [7:0] ptrZeroReg;
  reg [7:0] ptrZeroNext;
  reg [7:0] ptrOneReg;
  reg [7:0] ptrOneNext;
  wire zeroVal;
  wire signVal;
  wire ovfVal;
  wire halfVal;
  wire isWorkAddr;
  wire [7:0] workAbs;
  wire busWrite;
  wire busRead;

  // Register index to APB byte address.
  function [11:0] byteAddr;
    input [11:0] idx;
    begin
      byteAddr = `CFP_BYTE_ADDR(idx);
    end
  endfunction

  // Pointer value with fixed low bits zeroed.
  function [7:0] cleanPtr;
    input [7:0] val;
    begin
      cleanPtr = val & `CFP_PTR_MASK; // [RULE13]
    end
  endfunction

  // Flag values derived from the ALU result.
  cfp_flag_eval uFlagEval (
    .aluResult(aluResult),
    .aluOpA(aluOpA),
    .aluOpB(aluOpB),
    .aluIsSub(aluIsSub),
    .aluIsWord(aluIsWord),
    .zeroOut(zeroVal),
    .signOut(signVal),
    .ovfOut(ovfVal),
    .halfOut(halfVal)
  );

  // Working register address translation.
  cfp_addr_map uAddrMap (
    .ptrZero(ptrZeroReg),
    .ptrOne(ptrOneReg),
    .splitMode(ptrZeroReg[`CFP_PTR_SPLIT]),
    .workNum(regAddr[3:0]),
    .absAddr(workAbs)
  );

  // APB is zero wait state; every transfer completes in its access cycle.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign busWrite = psel && penable && pwrite;
  assign busRead = psel && !penable && !pwrite;

  // Flag register next value: hardware events override software writes.
  always @* begin
    flagsNext = flagsReg;
    if (busWrite && (paddr == byteAddr(`CFP_OFF_FLAGS))) begin
      flagsNext = pwdata[7:0];
    end
    if (aluCarryUpdate) begin
      flagsNext[`CFP_FLAG_CARRY] = aluCarryOut; // [RULE1]
    end
    if (set_msb_out) begin
      flagsNext[`CFP_FLAG_CARRY] = 1'b1; // [RULE2]
    end else if (clear_msb_out) begin
      flagsNext[`CFP_FLAG_CARRY] = 1'b0; // [RULE2]
    end else if (invert_msb_out) begin
      flagsNext[`CFP_FLAG_CARRY] = ~flagsReg[`CFP_FLAG_CARRY]; // [RULE2]
    end
    if (aluUpdate) begin
      flagsNext[`CFP_FLAG_ZERO] = zeroVal; // [RULE3]
      flagsNext[`CFP_FLAG_SIGN] = signVal; // [RULE4] [RULE5]
      flagsNext[`CFP_FLAG_OVF] = ovfVal; // [RULE6] [RULE5]
    end
    if (aluArith) begin
      flagsNext[`CFP_FLAG_BCDKIND] = aluIsSub; // [RULE7]
      if (!aluIsWord) begin
        flagsNext[`CFP_FLAG_HALF] = halfVal; // [RULE8]
      end
    end
    // The user bit moves only by its own commands or a register write.
    if (userSet) begin
      flagsNext[`CFP_FLAG_USER] = 1'b1; // [RULE9]
    end else if (userClear) begin
      flagsNext[`CFP_FLAG_USER] = 1'b0; // [RULE9]
    end
    if (select_data_space) begin
      flagsNext[`CFP_FLAG_MEMSEL] = 1'b1; // [RULE10]
    end else if (select_code_space) begin
      flagsNext[`CFP_FLAG_MEMSEL] = 1'b0; // [RULE10]
    end
  end

  // Pointer next values; every pointer command writes the split bit into both pointers.
  always @* begin
    ptrZeroNext = ptrZeroReg;
    ptrOneNext = ptrOneReg;
    if (busWrite && (paddr == byteAddr(`CFP_OFF_PTR0))) begin
      ptrZeroNext = cleanPtr(pwdata[7:0]); // [RULE13]
    end
    if (busWrite && (paddr == byteAddr(`CFP_OFF_PTR1))) begin
      ptrOneNext = cleanPtr(pwdata[7:0]); // [RULE13]
    end
    if (set_pointer_zero) begin
      ptrZeroNext = {cmdGroupIndex, 3'b000}; // [RULE14]
      ptrZeroNext[`CFP_PTR_SPLIT] = 1'b1; // [RULE11] [RULE12]
      ptrOneNext[`CFP_PTR_SPLIT] = 1'b1; // [RULE12]
    end else if (set_pointer_one) begin
      ptrOneNext = {cmdGroupIndex, 3'b000}; // [RULE14]
      ptrOneNext[`CFP_PTR_SPLIT] = 1'b1; // [RULE11] [RULE12]
      ptrZeroNext[`CFP_PTR_SPLIT] = 1'b1; // [RULE12]
    end else if (set_single_pointer) begin
      ptrZeroNext = {cmdGroupIndex, 3'b000}; // [RULE14]
      ptrZeroNext[`CFP_PTR_SPLIT] = 1'b0; // [RULE11] [RULE12]
      ptrOneNext[`CFP_PTR_SPLIT] = 1'b0; // [RULE12]
    end
  end

  // State registers.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flagsReg <= `CFP_FLAGS_RST;
      ptrZeroReg <= `CFP_PTR_RST;
      ptrOneReg <= `CFP_PTR_RST;
    end else begin
      flagsReg <= flagsNext;
      ptrZeroReg <= ptrZeroNext;
      ptrOneReg <= ptrOneNext;
    end
  end

  // Read data captured in the setup cycle, valid in the access cycle.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h00000000;
    end else if (busRead) begin
      if (paddr == byteAddr(`CFP_OFF_FLAGS)) begin
        prdata <= {24'h000000, flagsReg};
      end else if (paddr == byteAddr(`CFP_OFF_PTR0)) begin
        prdata <= {24'h000000, ptrZeroReg};
      end else if (paddr == byteAddr(`CFP_OFF_PTR1)) begin
        prdata <= {24'h000000, ptrOneReg};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Working register addressing uses group 0xD's slot in the high nibble.
  assign isWorkAddr = (regAddr[7:4] == `CFP_GROUP_D); // [RULE15]
  // Group D is only reached through the pointers; a direct reference is translated through them.
  assign absRegAddr = isWorkAddr ? workAbs : regAddr; // [RULE19]
  assign regAddrValid = 1'b1;

  assign condition_flags = flagsReg;
  assign memory_space_sel = flagsReg[`CFP_FLAG_MEMSEL];
  assign pointer_split_mode = ptrZeroReg[`CFP_PTR_SPLIT];
endmodule // cfp_core_regs
`default_nettype wire

// File: sim/cfp_core_regs_chk.sv
// Port checker for the flag and pointer block.
// Assumes it is bound to cfp_core_regs and that port names match.
`timescale 1ns/1ns
`default_nettype none
module cfp_core_regs_chk (
  // Clock, reset and bus.
  input wire logic sys_clk, rst_b, psel, penable, pwrite,
  input wire logic [11:0] paddr,
  // ALU results and decoder commands.
  input wire logic aluUpdate, aluCarryUpdate, aluArith, aluIsSub, aluIsWord, aluCarryOut,
  input wire logic [15:0] aluResult,
  input wire logic set_msb_out, clear_msb_out, invert_msb_out, userSet, userClear,
  input wire logic select_data_space, set_pointer_zero,
  // Address translation and state.
  input wire logic [7:0] regAddr, absRegAddr, condition_flags,
  input wire logic memory_space_sel, pointer_split_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Expected zero and sign for the width of the operation.
  wire zeroExp = aluIsWord ? aluResult == 16'h0000 : aluResult[7:0] == 8'h00;
  wire signExp = aluIsWord ? aluResult[15] : aluResult[7];
  wire flagWr = psel & penable & pwrite & (paddr == 12'h39c);
  wire carryCmd = set_msb_out | clear_msb_out | invert_msb_out;
  property p_set; set_msb_out |=> condition_flags[7]; endproperty
  a_set: assert property (p_set) else $error("carry not forced high");
  property p_clr; clear_msb_out && !set_msb_out && !aluCarryUpdate |=> !condition_flags[7]; endproperty
  a_clr: assert property (p_clr) else $error("carry not cleared");
  property p_inv; invert_msb_out && !set_msb_out && !clear_msb_out && !aluCarryUpdate
    ##1 1 |-> condition_flags[7] != $past(condition_flags[7]); endproperty
  a_inv: assert property (p_inv) else $error("carry not inverted");
  property p_cy; aluCarryUpdate && !carryCmd |=> condition_flags[7] == $past(aluCarryOut); endproperty
  a_cy: assert property (p_cy) else $error("carry not loaded");
  property p_zs; aluUpdate |=> condition_flags[6:5] == {$past(zeroExp), $past(signExp)}; endproperty
  a_zs: assert property (p_zs) else $error("zero or sign wrong");
  property p_kind; aluArith |=> condition_flags[3] == $past(aluIsSub); endproperty
  a_kind: assert property (p_kind) else $error("add or subtract kind wrong");
  property p_user; !userSet && !userClear && !flagWr |=> $stable(condition_flags[1]); endproperty
  a_user: assert property (p_user) else $error("user bit moved");
  property p_mem; select_data_space |=> memory_space_sel && condition_flags[0]; endproperty
  a_mem: assert property (p_mem) else $error("data space not selected");
  property p_split; set_pointer_zero |=> pointer_split_mode; endproperty
  a_split: assert property (p_split) else $error("twin mode not entered");
  property p_direct; regAddr[7:4] != 4'hd |-> absRegAddr == regAddr; endproperty
  a_direct: assert property (p_direct) else $error("direct address altered");
endmodule // cfp_core_regs_chk
bind cfp_core_regs cfp_core_regs_chk i_cfp_core_regs_chk (.*);
`default_nettype wire

// File: sim/tb_cfp_core_regs.sv
// Self-checking bench for the flag and pointer block.
// Assumes a zero-wait APB slave and one-cycle decoder pulses.
`timescale 1ns/1ns
`default_nettype none
module tb_cfp_core_regs;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, regAddrValid;
  logic aluIsSub = 0, aluIsWord = 0, aluCarryOut = 0, memory_space_sel, pointer_split_mode;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] aluResult = '0, aluOpA = '0, aluOpB = '0;
  logic [12:0] cmd = '0;
  logic [4:0] cmdGroupIndex = '0;
  logic [7:0] regAddr = '0, absRegAddr, condition_flags;
  int mismatches = 0, nChecks = 0;
  // Command pulses share one vector so a task can raise any set of them.
  cfp_core_regs i_cfp_core_regs (.*, .set_msb_out(cmd[0]), .clear_msb_out(cmd[1]), .invert_msb_out(cmd[2]),
    .userSet(cmd[3]), .userClear(cmd[4]), .select_data_space(cmd[5]), .select_code_space(cmd[6]),
    .set_pointer_zero(cmd[7]), .set_pointer_one(cmd[8]), .set_single_pointer(cmd[9]),
    .aluUpdate(cmd[10]), .aluCarryUpdate(cmd[11]), .aluArith(cmd[12]));
  // Clock of 8 ns.
  always #4 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finishTest;
    if (mismatches == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; read data lands in rd at the completing edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [12:0] m);
    @(posedge sys_clk);
    cmd <= m;
    @(posedge sys_clk);
    cmd <= '0;
    @(negedge sys_clk);
  endtask
  task automatic alu(input logic [12:0] m, input logic s, w, c, input logic [15:0] a, b, r);
    @(posedge sys_clk);
    {aluIsSub, aluIsWord, aluCarryOut, aluOpA, aluOpB, aluResult} <= {s, w, c, a, b, r};
    pulse(m);
  endtask
  task automatic addr(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    @(negedge sys_clk);
    chk(absRegAddr, e);
  endtask
  task automatic t_carry;
    pulse(13'h0001); chk(condition_flags[7], 1'b1);
    pulse(13'h0004); chk(condition_flags[7], 1'b0);
    pulse(13'h0004); chk(condition_flags[7], 1'b1);
    pulse(13'h0002); chk(condition_flags[7], 1'b0);
  endtask
  task automatic t_alu;
    alu(13'h1c00, 0, 0, 1, 16'h0080, 16'h0080, 16'h0100); chk(condition_flags[7:2], 6'b110100);
    alu(13'h1c00, 0, 1, 0, 16'h7fff, 16'h0001, 16'h8000); chk(condition_flags[7:3], 5'b00110);
    alu(13'h1c00, 0, 0, 0, 16'h000f, 16'h0001, 16'h0010); chk(condition_flags[7:2], 6'b000001);
    alu(13'h1c00, 1, 0, 0, 16'h0010, 16'h0001, 16'h000f); chk(condition_flags[7:2], 6'b000011);
    alu(13'h0400, 0, 0, 0, 16'h00f0, 16'h000f, 16'h0000); chk(condition_flags[6:2], 5'b10011);
  endtask
  task automatic t_user;
    pulse(13'h0008); chk(condition_flags[1], 1'b1);
    alu(13'h1c00, 0, 0, 0, 16'h0001, 16'h0001, 16'h0002); chk(condition_flags[1], 1'b1);
    pulse(13'h0010); chk(condition_flags[1], 1'b0);
    pulse(13'h0020); chk({memory_space_sel, condition_flags[0]}, 2'b11);
    pulse(13'h0040); chk({memory_space_sel, condition_flags[0]}, 2'b00);
  endtask
  task automatic t_ptr;
    @(posedge sys_clk);
    cmdGroupIndex <= 5'h1a;
    pulse(13'h0080);
    @(posedge sys_clk);
    cmdGroupIndex <= 5'h04;
    pulse(13'h0100); chk(pointer_split_mode, 1'b1);
    apb(0, 12'h3a0, '0); chk(rd, 32'h000000d4);
    apb(0, 12'h3a4, '0); chk(rd, 32'h00000024);
    addr(8'hd3, 8'd211);
    addr(8'hdc, 8'd36);
    @(posedge sys_clk);
    cmdGroupIndex <= 5'h07;
    pulse(13'h0200); chk(pointer_split_mode, 1'b0);
    // In single mode pointer one is only read back, never used for addressing.
    apb(0, 12'h3a4, '0); chk(rd, 32'h00000020);
    addr(8'hd5, 8'd53);
    addr(8'hdd, 8'd61);
    addr(8'h45, 8'h45);
  endtask
  task automatic t_apb;
    apb(1, 12'h3a0, 32'h000000ff);
    apb(0, 12'h3a0, '0); chk(rd, 32'h000000fc);
    apb(1, 12'h39c, 32'h000000a5);
    apb(1, 12'h3a8, 32'h000000ff);
    apb(0, 12'h39c, '0); chk(rd, 32'h000000a5);
    apb(0, 12'h3a8, '0); chk(rd, 32'h00000000);
    chk({pready, pslverr, regAddrValid}, 3'b101);
  endtask
  // Reset for six cycles, then run every scenario.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_carry;
    t_alu;
    t_user;
    t_ptr;
    t_apb;
    finishTest;
  end
  // Watchdog well beyond the hundred or so cycles the scenarios need.
  initial begin
    #20000;
    mismatches++;
    finishTest;
  end
endmodule // tb_cfp_core_regs
`default_nettype wire
